// File: src/lit_regs.svh
`ifndef LIT_REGS_SVH
`define LIT_REGS_SVH
// Functional notes
// RULE1: Scan seeing receive clock shift loads 32
// RULE2: Modem receive clock falling edge sets shift
// RULE3: Load 32 needs no oscillator change
// RULE4: Modem mode: oscillator change adds one
// RULE5: Software picks oscillator below half bit rate
// RULE6: Count wraps 63 to 0 gives strobe
// RULE7: Backup strobe samples data, requests service
// RULE8: Software treats backup-strobed characters as corrupt
// RULE9: Status read B: adapter, buffer, service
// RULE10: Control write A latched, driven to adapter
// RULE11: Status read A returns control write A
// RULE12: Control write B loads send data buffer
// RULE13: Status read C: write B, overrun, line
// RULE14: Receive mode strobes from bit timing
// RULE15: Transmit mode strobes from selected oscillator
// RULE16: Strobe falling edge sets service trigger
// RULE17: Scanner clears service before next strobe
// RULE18: Strobe with service still set: overrun
// RULE19: Scanner sets direction, request, data after service
// RULE20: Strobe loads transmit buffer, drives line
// RULE21: Line change while input differs from buffer
// RULE22: Strobe captures input into receive buffer
// RULE23: Six-bit strobe count per timing word
// RULE24: Sixteen timing words scanned in turn
// RULE25: Overrun holds until overrun reset
`define LIT_A_CTRL_A 8'h00
`define LIT_A_CTRL_B 8'h04
`define LIT_A_STAT_B 8'h08
`define LIT_A_STAT_C 8'h0C
`define LIT_A_CONFIG 8'h10
`define LIT_A_SERVICE 8'h14
`define LIT_A_TIMING 8'h18
`define LIT_B_XMIT 0
`define LIT_B_RTS 1
`define LIT_B_NSYNC 2
`define LIT_B_SDATA 3
`define LIT_C_TEST 2
`define LIT_C_TDATA 3
`define LIT_C_EXTCLK 4
`define LIT_S_SVC_RST 0
`define LIT_S_OVR_RST 1
`define LIT_RST_CTRL 8'h00
`define LIT_FORCE_CNT 6'h20
`define LIT_CLK_MHZ 200
`define LIT_SCAN_NS 400
`define LIT_OSC0_HALF_NS 6500
`define LIT_OSC1_HALF_NS 13000
`define LIT_OSC2_HALF_NS 26000
`define LIT_OSC3_HALF_NS 52000
`endif

// File: src/lit_pkg.sv
package lit_pkg;
   typedef logic [15:0] lit_cnt_t;
   // Timing word: last oscillator sample over six-bit count
   typedef struct packed {
      logic last_oscillator_sample;
      logic [5:0] count;
   } lit_word_s;
   typedef struct packed {
      logic [7:0] ctl_a;
      logic [3:0] ctl_b;
      logic [4:0] cfg;
      logic send_buf;
      logic tx_buf;
      logic rx_buf;
      logic line_chg;
      logic bit_svc;
      logic bit_ovr;
      logic [1:0] rxclk_sync;
      logic rxclk_last;
      logic shift_pend;
      logic [1:0] rxd_sync;
      logic [1:0][7:0] sts_sync;
      logic [3:0] osc;
      logic [3:0][15:0] osc_cnt;
      logic tx_last_oscillator_sample;
      logic [5:0] tx_div;
      logic [6:0] scan_cnt;
      logic [3:0] scan_sel;
      lit_word_s [15:0] bcc;
      logic [31:0] prdata;
      logic pslverr;
   } lit_state_s;
endpackage

// File: src/lit_line_interface.sv
`timescale 1ns/1ps
`default_nettype none
`include "lit_regs.svh"
module lit_line_interface
   import lit_pkg::*;
#(
   parameter logic [3:0] LINE_ID = 4'h0,
   parameter lit_cnt_t OSC0_HALF = lit_cnt_t'(`LIT_OSC0_HALF_NS * `LIT_CLK_MHZ / 1000),
   parameter lit_cnt_t OSC1_HALF = lit_cnt_t'(`LIT_OSC1_HALF_NS * `LIT_CLK_MHZ / 1000),
   parameter lit_cnt_t OSC2_HALF = lit_cnt_t'(`LIT_OSC2_HALF_NS * `LIT_CLK_MHZ / 1000),
   parameter lit_cnt_t OSC3_HALF = lit_cnt_t'(`LIT_OSC3_HALF_NS * `LIT_CLK_MHZ / 1000)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Modem or line adapter pins
   input wire logic modem_rx_clk,
   input wire logic rx_data,
   input wire logic [7:0] adapter_sts,
   output logic [7:0] adapter_ctrl,
   output logic tx_data,
   output logic req_to_send,
   output logic new_sync,
   // Service request lines
   output logic bit_service,
   output logic bit_overrun
);
   localparam logic [6:0] SCAN_CYC = 7'(`LIT_SCAN_NS * `LIT_CLK_MHZ / 1000);
   localparam logic [3:0][15:0] OSC_HALF = {OSC3_HALF, OSC2_HALF, OSC1_HALF, OSC0_HALF};

   lit_state_s q;
   lit_state_s n;

   logic rx_fall;
   logic present_oscillator_sample;
   logic tx_tick;
   logic scan_tick;
   logic own_line;
   logic bcc_strobe;
   logic strobe;
   logic chosen_in;
   logic setup_ph;
   logic wr_acc;
   logic svc_clr;
   logic ovr_clr;
   logic [5:0] inc_cnt;
   lit_word_s w;

   // ---------------------------------------------
   // Next-state logic
   // ---------------------------------------------
   always_comb begin
      n = q;
      rx_fall = 1'b0;
      tx_tick = 1'b0;
      bcc_strobe = 1'b0;
      svc_clr = 1'b0;
      ovr_clr = 1'b0;
      w = q.bcc[q.scan_sel];
      inc_cnt = 6'(w.count + 6'h01);
      own_line = (q.scan_sel == LINE_ID);
      scan_tick = (q.scan_cnt == 7'(SCAN_CYC - 7'h01));
      setup_ph = psel && !penable;
      wr_acc = psel && penable && pwrite;

      // Pin synchronisers; stage 0 feeds stage 1 only
      n.rxclk_sync = {q.rxclk_sync[0], modem_rx_clk};
      n.rxd_sync = {q.rxd_sync[0], rx_data};
      n.sts_sync = {q.sts_sync[0], adapter_sts};
      n.rxclk_last = q.rxclk_sync[1];
      rx_fall = q.rxclk_last && !q.rxclk_sync[1];

      // Business machine oscillators
      for (int i = 0; i < 4; i++) begin
         if (q.osc_cnt[i] >= 16'(OSC_HALF[i] - 16'h0001)) begin
            n.osc_cnt[i] = 16'h0000;
            n.osc[i] = !q.osc[i];
         end else begin
            n.osc_cnt[i] = 16'(q.osc_cnt[i] + 16'h0001);
         end
      end
      present_oscillator_sample = q.osc[q.cfg[1:0]];

      // Transmit bit clock: 64 selected oscillator changes per bit
      if (present_oscillator_sample != q.tx_last_oscillator_sample) begin
         n.tx_last_oscillator_sample = present_oscillator_sample;
         n.tx_div = 6'(q.tx_div + 6'h01);
         tx_tick = (q.tx_div == 6'h3F);
      end

      // Timing word scan, one word per slot
      if (scan_tick) begin
         n.scan_cnt = 7'h00;
         n.scan_sel = 4'(q.scan_sel + 4'h1); // [RULE24]
         if (own_line && q.shift_pend) begin
            n.bcc[q.scan_sel].count = `LIT_FORCE_CNT; // [RULE1] [RULE3]
         end else if (present_oscillator_sample != w.last_oscillator_sample) begin
            n.bcc[q.scan_sel].last_oscillator_sample = present_oscillator_sample;
            n.bcc[q.scan_sel].count = inc_cnt; // [RULE4] [RULE23]
            // Stopped modem clock: wrap gives a backup strobe
            bcc_strobe = own_line && (inc_cnt == 6'h00); // [RULE6]
         end
      end else begin
         n.scan_cnt = 7'(q.scan_cnt + 7'h01);
      end

      // Strobe source by direction
      strobe = q.ctl_b[`LIT_B_XMIT] ? tx_tick : bcc_strobe; // [RULE14] [RULE15]
      chosen_in = q.cfg[`LIT_C_TEST] ? q.cfg[`LIT_C_TDATA] : q.rxd_sync[1];

      // APB writes
      if (wr_acc) begin
         unique case (paddr)
            `LIT_A_CTRL_A: n.ctl_a = pwdata[7:0]; // [RULE10]
            `LIT_A_CTRL_B: begin
               n.ctl_b = pwdata[3:0];
               n.send_buf = pwdata[`LIT_B_SDATA]; // [RULE12]
            end
            `LIT_A_CONFIG: n.cfg = pwdata[4:0];
            `LIT_A_SERVICE: begin
               svc_clr = pwdata[`LIT_S_SVC_RST];
               ovr_clr = pwdata[`LIT_S_OVR_RST];
            end
            default: ;
         endcase
      end

      // Receive clock shift; set wins over the scan's clear
      n.shift_pend = (rx_fall && q.cfg[`LIT_C_EXTCLK]) // [RULE2]
         || (q.shift_pend && !(scan_tick && own_line));

      // Line change compare
      n.line_chg = (chosen_in != q.rx_buf); // [RULE21]

      // Strobe falling edge actions
      if (strobe) begin
         n.rx_buf = chosen_in; // [RULE22] [RULE7]
         n.tx_buf = q.send_buf; // [RULE20]
      end
      n.bit_svc = strobe || (q.bit_svc && !svc_clr); // [RULE16] [RULE7]
      n.bit_ovr = (strobe && q.bit_svc) || (q.bit_ovr && !ovr_clr); // [RULE18] [RULE25]

      // APB read data captured in setup phase
      if (setup_ph) begin
         n.pslverr = 1'b0;
         n.prdata = 32'h0000_0000;
         unique case (paddr)
            `LIT_A_CTRL_A: n.prdata[7:0] = q.ctl_a; // [RULE11]
            `LIT_A_CTRL_B: n.prdata[3:0] = q.ctl_b;
            `LIT_A_STAT_B: n.prdata[9:0] = {q.bit_svc, q.rx_buf, q.sts_sync[1]}; // [RULE9]
            `LIT_A_STAT_C: n.prdata[6:0] = {q.line_chg, chosen_in, q.bit_ovr, q.ctl_b}; // [RULE13]
            `LIT_A_CONFIG: n.prdata[4:0] = q.cfg;
            `LIT_A_SERVICE: ;
            `LIT_A_TIMING: n.prdata[7:0] = {q.shift_pend, q.bcc[LINE_ID]};
            default: n.pslverr = 1'b1;
         endcase
      end
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign prdata = q.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && q.pslverr;
   assign adapter_ctrl = q.ctl_a;
   assign tx_data = q.tx_buf;
   assign req_to_send = q.ctl_b[`LIT_B_RTS];
   assign new_sync = q.ctl_b[`LIT_B_NSYNC];
   assign bit_service = q.bit_svc;
   assign bit_overrun = q.bit_ovr;

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   logic [5:0] own_cnt;
   assign own_cnt = q.bcc[LINE_ID].count;

   sequence s_own_scan;
      scan_tick && own_line;
   endsequence

   sequence s_read_a;
      psel && !penable && !pwrite && (paddr == `LIT_A_CTRL_A);
   endsequence

   sequence s_write_a;
      psel && penable && pwrite && (paddr == `LIT_A_CTRL_A);
   endsequence

   AST_FORCE32: assert property (s_own_scan and q.shift_pend |=> own_cnt == 6'h20) // [RULE1]
      else $error("Count not forced to 32");
   AST_SHIFT_SET: assert property (rx_fall && q.cfg[`LIT_C_EXTCLK] |=> q.shift_pend) // [RULE2]
      else $error("Clock shift not recorded");
   AST_ADD_ONE: assert property (s_own_scan and (!q.shift_pend && present_oscillator_sample != w.last_oscillator_sample)
      |=> own_cnt == 6'($past(own_cnt) + 6'h01)) // [RULE4]
      else $error("Count did not advance on oscillator change");
   AST_WRAP: assert property (bcc_strobe |=> own_cnt == 6'h00 && $past(own_cnt) == 6'h3F) // [RULE6]
      else $error("Backup strobe without wrap");
   AST_SVC: assert property (strobe |=> q.bit_svc ##1 (q.bit_svc || $past(svc_clr))) // [RULE16]
      else $error("Service trigger not set by strobe");
   AST_OVR: assert property (strobe && q.bit_svc |=> q.bit_ovr) // [RULE18]
      else $error("Overrun not set");
   AST_OVR_HOLD: assert property (q.bit_ovr && !ovr_clr |=> q.bit_ovr) // [RULE25]
      else $error("Overrun dropped without reset");
   AST_RXBUF: assert property (strobe |=> q.rx_buf == $past(chosen_in)) // [RULE22]
      else $error("Receive buffer missed strobe");
   AST_TXBUF: assert property (strobe |=> tx_data == $past(q.send_buf)) // [RULE20]
      else $error("Transmit buffer missed strobe");
   AST_SRC: assert property (strobe && !q.ctl_b[`LIT_B_XMIT] |-> bcc_strobe) // [RULE14]
      else $error("Receive strobe from wrong source");
   AST_TX_SRC: assert property (strobe && q.ctl_b[`LIT_B_XMIT] |-> tx_tick) // [RULE15]
      else $error("Transmit strobe from wrong source");
   AST_CTRL_A: assert property (s_write_a |=> adapter_ctrl == $past(pwdata[7:0])) // [RULE10]
      else $error("Control write A not latched");
   AST_READ_A: assert property (s_read_a |=> prdata[7:0] == adapter_ctrl) // [RULE11]
      else $error("Status read A mismatch");
   AST_LCHG: assert property (##1 q.line_chg == $past(chosen_in != q.rx_buf)) // [RULE21]
      else $error("Line change flag wrong");
endmodule
`default_nettype wire

// File: bench/lit_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module lit_modem_model (
   // Scenario controls
   input wire logic run,
   input wire logic rxd_level,
   input wire logic [7:0] sts_level,
   // Line side
   output logic modem_rx_clk,
   output logic rx_data,
   output logic [7:0] adapter_sts
);
   // ----
   // Receive clock, 125 ns period, parked high between frames
   // ----
   initial begin
      modem_rx_clk = 1'b1;
      forever begin
         #62.5;
         modem_rx_clk = run ? ~modem_rx_clk : 1'b1;
      end
   end
   // Data and status stay driven even while the clock is parked
   assign rx_data = rxd_level;
   assign adapter_sts = sts_level;
endmodule
`default_nettype wire

// File: bench/lit_line_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "lit_regs.svh"
module lit_line_interface_test;
   typedef struct packed {
      logic [7:0] adr_w;
      logic [31:0] dat_w;
      logic [7:0] adr_r;
      logic [31:0] exp_r;
      logic err;
   } lit_row_s;
   lit_row_s rows [7];
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr, adapter_sts, adapter_ctrl;
   logic [31:0] pwdata, prdata, q;
   logic modem_rx_clk, rx_data, tx_data, req_to_send, new_sync, bit_service, bit_overrun, run, rxd_level;
   int mismatches, tests_run;

   lit_line_interface #(
      .OSC0_HALF(16'h0005),
      .OSC1_HALF(16'h0514),
      .OSC2_HALF(16'h0008),
      .OSC3_HALF(16'h000A)
   ) dut (
      .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .modem_rx_clk(modem_rx_clk), .rx_data(rx_data), .adapter_sts(adapter_sts),
      .adapter_ctrl(adapter_ctrl), .tx_data(tx_data), .req_to_send(req_to_send),
      .new_sync(new_sync), .bit_service(bit_service), .bit_overrun(bit_overrun)
   );
   lit_modem_model modem (
      .run(run), .rxd_level(rxd_level), .sts_level(8'h5A),
      .modem_rx_clk(modem_rx_clk), .rx_data(rx_data), .adapter_sts(adapter_sts)
   );

   // ----
   // Shared tasks
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Called just after a rising edge; one idle edge after release avoids double drives
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      check(32'(n < 50), 32'h0000_0001);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Samples on the falling edge, where registered outputs have settled
   task automatic wait_sig(input logic ovr, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while ((ovr ? bit_overrun : bit_service) !== 1'b1 && n < lim);
      check(32'(n < lim), 32'h0000_0001);
      @(posedge clk);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ----
   // Clock and watchdog
   // ----
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      close_out();
   end

   // ----
   // Main sequence
   // ----
   initial begin
      {reset_n, psel, penable, pwrite, run} = 5'h00;
      {paddr, pwdata, rxd_level} = {8'h00, 32'h0000_0000, 1'b1};
      rows[0] = '{`LIT_A_CTRL_A, 32'h0000_00A5, `LIT_A_CTRL_A, 32'h0000_00A5, 1'b0};
      rows[1] = '{`LIT_A_CTRL_B, 32'h0000_0006, `LIT_A_STAT_C, 32'h0000_0066, 1'b0};
      rows[2] = '{`LIT_A_CONFIG, 32'h0000_0004, `LIT_A_STAT_C, 32'h0000_0006, 1'b0};
      rows[3] = '{`LIT_A_CONFIG, 32'h0000_000C, `LIT_A_STAT_C, 32'h0000_0066, 1'b0};
      rows[4] = '{`LIT_A_SERVICE, 32'h0000_0000, `LIT_A_SERVICE, 32'h0000_0000, 1'b0};
      rows[5] = '{8'h1C, 32'h0000_FFFF, 8'h1C, 32'h0000_0000, 1'b1};
      rows[6] = '{`LIT_A_CONFIG, 32'h0000_0000, `LIT_A_STAT_B, 32'h0000_005A, 1'b0};
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      check(32'({adapter_ctrl, tx_data, req_to_send, new_sync, bit_service, bit_overrun, pready, pslverr}),
         32'h0000_0002);
      $display("test reset done");
      foreach (rows[i]) begin
         apb(1'b1, rows[i].adr_w, rows[i].dat_w);
         check(32'(e), 32'(rows[i].err));
         apb(1'b0, rows[i].adr_r, 32'h0000_0000);
         check(q, rows[i].exp_r);
         check(32'(e), 32'(rows[i].err));
      end
      check(32'({adapter_ctrl, new_sync, req_to_send}), 32'h0000_0297);
      $display("test register table done");
      // Transmit with send data set; service left pending to force an overrun
      apb(1'b1, `LIT_A_CTRL_B, 32'h0000_0009);
      wait_sig(1'b0, 2000);
      check(32'(tx_data), 32'h0000_0001);
      apb(1'b0, `LIT_A_STAT_B, 32'h0000_0000);
      check(q, 32'h0000_035A);
      wait_sig(1'b1, 2000);
      apb(1'b0, `LIT_A_STAT_C, 32'h0000_0000);
      check(q, 32'h0000_0039);
      apb(1'b1, `LIT_A_SERVICE, 32'h0000_0001);
      check(32'({bit_service, bit_overrun}), 32'h0000_0001);
      apb(1'b1, `LIT_A_SERVICE, 32'h0000_0002);
      apb(1'b1, `LIT_A_CTRL_B, 32'h0000_0000);
      check(32'({bit_service, bit_overrun}), 32'h0000_0000);
      $display("test transmit and overrun done");
      // Modem clocked receive on the slow oscillator
      apb(1'b1, `LIT_A_CONFIG, 32'h0000_0011);
      run <= 1'b1;
      repeat (3000) @(posedge clk);
      apb(1'b0, `LIT_A_TIMING, 32'h0000_0000);
      check(32'(q[5:0]), 32'h0000_0020);
      check(32'(bit_service), 32'h0000_0000);
      run <= 1'b0;
      rxd_level <= 1'b0;
      wait_sig(1'b0, 50000);
      apb(1'b0, `LIT_A_STAT_B, 32'h0000_0000);
      check(q, 32'h0000_025A);
      apb(1'b0, `LIT_A_TIMING, 32'h0000_0000);
      check(32'(q[5:0]), 32'h0000_0000);
      // Software discards the backup-strobed character and acknowledges
      apb(1'b1, `LIT_A_SERVICE, 32'h0000_0001);
      check(32'(bit_service), 32'h0000_0000);
      $display("test backup strobe done");
      // Mid-run reset must clear the latched settings again
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      check(32'({adapter_ctrl, tx_data, req_to_send, new_sync, bit_service, bit_overrun, pready, pslverr}),
         32'h0000_0002);
      @(posedge clk);
      apb(1'b0, `LIT_A_CTRL_A, 32'h0000_0000);
      check(q, 32'h0000_0000);
      $display("test mid-run reset done");
      close_out();
   end
endmodule
`default_nettype wire
